// ===== rtl/tmr_unit.sv
// Operation
// - Capture sets flag and copies counter
// - Wrap flag on forward or backward rollover
// - Flag clears by read-set then write zero
// - Three request lines per channel, fifteen
// - Request equals flag and enable together
// - Default priority channel 0 A first
// - Clear beats counter write in T3
// - Word write in T3 beats count pulse
// - Byte write T2/T3 skips count, keeps byte
// - GR write in T3 suppresses match
// - Write beats wrap count, flag still set
// - GR read in T3 returns pre-capture value
// - Capture clear beats count, stores old value
// - Capture beats GR write in T3
// - Match clear gives period of N+1
// - Capture beats buffer write in T3
// - Write to synced counter sets all synced
// - PWM: no capture, simultaneous matches inhibited
// - Match event on last cycle of equality
`timescale 1ns/1ns
`default_nettype none
module tmr_unit
  import tmr_pkg::*;
#(
  parameter int CHANS = TMR_CHANS,
  parameter logic [15:0] GR_INIT = TMR_GR_RESET
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire tmr_bus_t bus,
  input wire tmr_cfg_t cfg [CHANS],
  input wire tmr_evt_t evt [CHANS],
  output logic [15:0] rdata_q,
  output logic rvalid_q,
  output logic [15:0] count_q [CHANS],
  output logic [CHANS*3-1:0] irq,
  output logic irq_any,
  output logic [3:0] irq_top
);

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
                                        input logic hi, input logic lo);
    logic [15:0] r;
    r = old;
    if (hi) r[15:8] = wd[15:8];
    if (lo) r[7:0] = wd[7:0];
    return r;
  endfunction

  function automatic logic [3:0] first_set(input logic [CHANS*3-1:0] v);
    logic [3:0] idx;
    idx = TMR_IDX_NONE;
    for (int k = CHANS * 3 - 1; k >= 0; k--) begin
      if (v[k]) idx = 4'(k);
    end
    return idx;
  endfunction

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  logic [15:0] gra_q [CHANS];
  logic [15:0] grb_q [CHANS];
  logic [15:0] bra_q [CHANS];
  logic [15:0] brb_q [CHANS];
  logic [CHANS*3-1:0] flags;

  logic wr_t3;
  logic rd_t3;
  logic byte_wr;
  logic [15:0] cnt_wval;
  logic any_sync_clr;
  logic [CHANS-1:0] in_scope;
  logic [CHANS-1:0] cnt_load;
  logic [CHANS-1:0] cnt_hold;
  logic [CHANS-1:0] cap_a;
  logic [CHANS-1:0] cap_b;
  logic [CHANS-1:0] match_a;
  logic [CHANS-1:0] match_b;
  logic [CHANS-1:0] own_clr;
  logic [CHANS-1:0] clr;
  logic [CHANS-1:0] wrap_evt;
  logic [CHANS-1:0] gra_wr;
  logic [CHANS-1:0] grb_wr;
  logic [CHANS-1:0] bra_wr;
  logic [CHANS-1:0] brb_wr;
  logic [CHANS-1:0] buf_ok;

  // ------------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------------
  assign wr_t3 = bus.wr && bus.phase == TMR_PH_T3;
  assign rd_t3 = bus.rd && bus.phase == TMR_PH_T3;
  assign byte_wr = bus.hi_en ^ bus.lo_en;
  assign cnt_wval = merge(count_q[bus.chan], bus.wdata, bus.hi_en, bus.lo_en);

  // ------------------------------------------------------------------
  // Per channel events
  // ------------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < CHANS; i++) begin
      // Synced channels follow a counter write to any one of them
      in_scope[i] = (int'(bus.chan) == i) ||
                    (cfg[i].sync && int'(bus.chan) < CHANS && cfg[bus.chan].sync);
      cnt_load[i] = wr_t3 && bus.target == TMR_TGT_CNT && in_scope[i];
      cnt_hold[i] = bus.wr && bus.target == TMR_TGT_CNT && in_scope[i] && byte_wr &&
                    (bus.phase == TMR_PH_T2 || bus.phase == TMR_PH_T3);
      gra_wr[i] = wr_t3 && bus.target == TMR_TGT_GRA && int'(bus.chan) == i;
      grb_wr[i] = wr_t3 && bus.target == TMR_TGT_GRB && int'(bus.chan) == i;
      bra_wr[i] = wr_t3 && bus.target == TMR_TGT_BRA && int'(bus.chan) == i;
      brb_wr[i] = wr_t3 && bus.target == TMR_TGT_BRB && int'(bus.chan) == i;
      buf_ok[i] = i >= TMR_BUF_FIRST;
      cap_a[i] = evt[i].cap_a && cfg[i].cap_a && !cfg[i].pwm;
      cap_b[i] = evt[i].cap_b && cfg[i].cap_b && !cfg[i].pwm;
      // Match fires as the counter leaves the equal value
      match_a[i] = evt[i].count_pulse && !cfg[i].cap_a && count_q[i] == gra_q[i] &&
                   !gra_wr[i];
      match_b[i] = evt[i].count_pulse && !cfg[i].cap_b && count_q[i] == grb_q[i] &&
                   !grb_wr[i];
      if (cfg[i].pwm && match_a[i] && match_b[i]) begin
        match_a[i] = 1'b0;
        match_b[i] = 1'b0;
      end
      own_clr[i] = (cfg[i].clr_sel == TMR_CLR_A && (match_a[i] || cap_a[i])) ||
                   (cfg[i].clr_sel == TMR_CLR_B && (match_b[i] || cap_b[i]));
    end
  end

  // ------------------------------------------------------------------
  // Synchronous clear fan-out
  // ------------------------------------------------------------------
  always_comb begin
    any_sync_clr = 1'b0;
    for (int i = 0; i < CHANS; i++) begin
      any_sync_clr = any_sync_clr | (own_clr[i] & cfg[i].sync);
    end
  end

  // ------------------------------------------------------------------
  // Counter clear and wrap detection
  // ------------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < CHANS; i++) begin
      clr[i] = own_clr[i] ||
               (cfg[i].clr_sel == TMR_CLR_SYNC && cfg[i].sync && any_sync_clr);
      wrap_evt[i] = evt[i].count_pulse && !clr[i] &&
                    (cfg[i].count_down ? count_q[i] == TMR_CNT_MIN
                                       : count_q[i] == TMR_CNT_MAX);
    end
  end

  // ------------------------------------------------------------------
  // Counters
  // ------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < CHANS; i++) count_q[i] <= TMR_CNT_RESET;
    end else begin
      for (int i = 0; i < CHANS; i++) begin
        if (clr[i]) begin
          count_q[i] <= TMR_CNT_RESET;
        end else if (cnt_load[i]) begin
          count_q[i] <= cnt_wval;
        end else if (cnt_hold[i]) begin
          count_q[i] <= count_q[i];
        end else if (evt[i].count_pulse) begin
          count_q[i] <= cfg[i].count_down ? count_q[i] - TMR_CNT_ONE
                                          : count_q[i] + TMR_CNT_ONE;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // General registers A
  // ------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < CHANS; i++) gra_q[i] <= GR_INIT;
    end else begin
      for (int i = 0; i < CHANS; i++) begin
        if (cap_a[i]) begin
          gra_q[i] <= count_q[i];
        end else if (gra_wr[i]) begin
          gra_q[i] <= merge(gra_q[i], bus.wdata, bus.hi_en, bus.lo_en);
        end else if (match_a[i] && cfg[i].buf_a && buf_ok[i]) begin
          gra_q[i] <= bra_q[i];
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // General registers B
  // ------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < CHANS; i++) grb_q[i] <= GR_INIT;
    end else begin
      for (int i = 0; i < CHANS; i++) begin
        if (cap_b[i]) begin
          grb_q[i] <= count_q[i];
        end else if (grb_wr[i]) begin
          grb_q[i] <= merge(grb_q[i], bus.wdata, bus.hi_en, bus.lo_en);
        end else if (match_b[i] && cfg[i].buf_b && buf_ok[i]) begin
          grb_q[i] <= brb_q[i];
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Buffer registers
  // ------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < CHANS; i++) begin
        bra_q[i] <= GR_INIT;
        brb_q[i] <= GR_INIT;
      end
    end else begin
      for (int i = 0; i < CHANS; i++) begin
        if (cap_a[i] && cfg[i].buf_a && buf_ok[i]) begin
          bra_q[i] <= gra_q[i];
        end else if (bra_wr[i]) begin
          bra_q[i] <= merge(bra_q[i], bus.wdata, bus.hi_en, bus.lo_en);
        end
        if (cap_b[i] && cfg[i].buf_b && buf_ok[i]) begin
          brb_q[i] <= grb_q[i];
        end else if (brb_wr[i]) begin
          brb_q[i] <= merge(brb_q[i], bus.wdata, bus.hi_en, bus.lo_en);
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Read data, sampled before this edge's capture lands
  // ------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 16'h0000;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= rd_t3;
      if (rd_t3 && int'(bus.chan) < CHANS) begin
        case (bus.target)
          TMR_TGT_CNT: rdata_q <= count_q[bus.chan];
          TMR_TGT_GRA: rdata_q <= gra_q[bus.chan];
          TMR_TGT_GRB: rdata_q <= grb_q[bus.chan];
          TMR_TGT_BRA: rdata_q <= bra_q[bus.chan];
          TMR_TGT_BRB: rdata_q <= brb_q[bus.chan];
          TMR_TGT_STAT: rdata_q <= {13'h0000, flags[bus.chan*3 +: 3]};
          default: rdata_q <= 16'h0000;
        endcase
      end else if (rd_t3) begin
        rdata_q <= 16'h0000;
      end
    end
  end

  // ------------------------------------------------------------------
  // Status flags and request lines
  // ------------------------------------------------------------------
  for (genvar g = 0; g < CHANS; g++) begin : g_chan
    logic rd_st;
    logic wr_st;
    logic [2:0] set_v;
    assign rd_st = rd_t3 && bus.target == TMR_TGT_STAT && int'(bus.chan) == g;
    assign wr_st = wr_t3 && bus.target == TMR_TGT_STAT && int'(bus.chan) == g && bus.lo_en;
    assign set_v[TMR_FLAG_A] = match_a[g] | cap_a[g];
    assign set_v[TMR_FLAG_B] = match_b[g] | cap_b[g];
    assign set_v[TMR_FLAG_WRAP] = wrap_evt[g];
    for (genvar f = 0; f < TMR_FLAGS_PER_CH; f++) begin : g_flag
      tmr_flag u_flag (
        .clock(clock),
        .rst_n(rst_n),
        .set(set_v[f]),
        .rd_stat(rd_st),
        .wr_stat(wr_st),
        .wbit(bus.wdata[f]),
        .en(cfg[g].irq_en[f]),
        .flag_q(flags[g*3+f]),
        .irq(irq[g*3+f])
      );
    end
  end

  // ------------------------------------------------------------------
  // Request summary, lowest index first
  // ------------------------------------------------------------------
  assign irq_any = |irq;
  assign irq_top = first_set(irq);

endmodule // tmr_unit
`default_nettype wire

// ===== rtl/tmr_pkg.sv
package tmr_pkg;

  // ------------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------------
  localparam int TMR_CHANS = 5;
  localparam int TMR_CNT_W = 16;
  localparam int TMR_FLAGS_PER_CH = 3;
  localparam int TMR_IRQS = TMR_CHANS * TMR_FLAGS_PER_CH;
  localparam int TMR_BUF_FIRST = 3;

  // ------------------------------------------------------------------
  // Bus cycle phases and targets
  // ------------------------------------------------------------------
  localparam logic [1:0] TMR_PH_IDLE = 2'h0;
  localparam logic [1:0] TMR_PH_T1 = 2'h1;
  localparam logic [1:0] TMR_PH_T2 = 2'h2;
  localparam logic [1:0] TMR_PH_T3 = 2'h3;

  localparam logic [2:0] TMR_TGT_CNT = 3'h0;
  localparam logic [2:0] TMR_TGT_GRA = 3'h1;
  localparam logic [2:0] TMR_TGT_GRB = 3'h2;
  localparam logic [2:0] TMR_TGT_BRA = 3'h3;
  localparam logic [2:0] TMR_TGT_BRB = 3'h4;
  localparam logic [2:0] TMR_TGT_STAT = 3'h5;

  // ------------------------------------------------------------------
  // Status bit positions and clear sources
  // ------------------------------------------------------------------
  localparam int TMR_FLAG_A = 0;
  localparam int TMR_FLAG_B = 1;
  localparam int TMR_FLAG_WRAP = 2;

  localparam logic [1:0] TMR_CLR_NONE = 2'h0;
  localparam logic [1:0] TMR_CLR_A = 2'h1;
  localparam logic [1:0] TMR_CLR_B = 2'h2;
  localparam logic [1:0] TMR_CLR_SYNC = 2'h3;

  // ------------------------------------------------------------------
  // Reset values and boundaries
  // ------------------------------------------------------------------
  localparam logic [15:0] TMR_CNT_RESET = 16'h0000;
  localparam logic [15:0] TMR_GR_RESET = 16'hFFFF;
  localparam logic [15:0] TMR_CNT_MAX = 16'hFFFF;
  localparam logic [15:0] TMR_CNT_MIN = 16'h0000;
  localparam logic [15:0] TMR_CNT_ONE = 16'h0001;
  localparam logic [3:0] TMR_IDX_NONE = 4'hF;

  // ------------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic rd;
    logic wr;
    logic [1:0] phase;
    logic [2:0] chan;
    logic [2:0] target;
    logic hi_en;
    logic lo_en;
    logic [15:0] wdata;
  } tmr_bus_t;

  typedef struct packed {
    logic [1:0] clr_sel;
    logic cap_a;
    logic cap_b;
    logic pwm;
    logic buf_a;
    logic buf_b;
    logic sync;
    logic count_down;
    logic [2:0] irq_en;
  } tmr_cfg_t;

  typedef struct packed {
    logic count_pulse;
    logic cap_a;
    logic cap_b;
  } tmr_evt_t;

endpackage

// ===== rtl/tmr_flag.sv
`timescale 1ns/1ns
`default_nettype none
module tmr_flag
  import tmr_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic set,
  input wire logic rd_stat,
  input wire logic wr_stat,
  input wire logic wbit,
  input wire logic en,
  output logic flag_q,
  output logic irq
);

  logic armed_q;

  // ------------------------------------------------------------------
  // Read-while-set arming
  // ------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      armed_q <= 1'b0;
    end else if (wr_stat) begin
      armed_q <= 1'b0;
    end else if (rd_stat && flag_q) begin
      armed_q <= 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // Sticky flag, set beats clear
  // ------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= 1'b0;
    end else if (set) begin
      flag_q <= 1'b1;
    end else if (wr_stat && !wbit && armed_q) begin
      flag_q <= 1'b0;
    end
  end

  assign irq = flag_q & en;

endmodule // tmr_flag
`default_nettype wire

// ===== verification/tmr_unit_props.sv
`timescale 1ns/1ns
`default_nettype none
module tmr_unit_props
  import tmr_pkg::*;
#(
  parameter int CHANS = TMR_CHANS
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire tmr_bus_t bus,
  input wire tmr_cfg_t cfg [CHANS],
  input wire tmr_evt_t evt [CHANS],
  input wire logic [15:0] rdata_q,
  input wire logic rvalid_q,
  input wire logic [15:0] count_q [CHANS],
  input wire logic [CHANS*3-1:0] irq,
  input wire logic irq_any,
  input wire logic [3:0] irq_top
);
  // ------------------------------------------------------------------
  // Port relations
  // ------------------------------------------------------------------
  logic [CHANS*3-1:0] low_mask;
  logic wr_cnt0;
  logic cap0;
  assign low_mask = ~({(CHANS*3){1'b1}} << irq_top);
  assign wr_cnt0 = bus.wr && bus.phase == TMR_PH_T3 && bus.chan == 3'h0
    && bus.target == TMR_TGT_CNT;
  assign cap0 = evt[0].cap_a && cfg[0].cap_a && !cfg[0].pwm;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_read_answer: assert property (rvalid_q == $past(bus.rd && bus.phase == TMR_PH_T3))
    else $error("read answer not one cycle after T3");
  a_irq_any_or: assert property (irq_any == (irq != '0))
    else $error("summary request disagrees with lines");
  a_top_none: assert property (!irq_any |-> irq_top == TMR_IDX_NONE)
    else $error("top index not none while idle");
  a_top_lowest: assert property (irq_any |-> irq[irq_top] && (irq & low_mask) == '0)
    else $error("top index not the highest priority request");
  a_write_beats_count: assert property (wr_cnt0 && bus.hi_en && bus.lo_en
    && evt[0].count_pulse && cfg[0].clr_sel == TMR_CLR_NONE && !cfg[0].sync
    |=> count_q[0] == $past(bus.wdata)) else $error("count pulse beat a word write");
  a_clear_on_cap: assert property (cap0 && cfg[0].clr_sel == TMR_CLR_A
    |=> count_q[0] == TMR_CNT_MIN) else $error("capture clear lost");
  a_capture_flag: assert property (cap0 && cfg[0].irq_en == 3'h7 |=> irq[0] && irq_any)
    else $error("capture did not raise its request");
  a_wrap_up: assert property (count_q[0] == TMR_CNT_MAX && evt[0].count_pulse
    && !cfg[0].count_down && cfg[0].clr_sel == TMR_CLR_NONE && !cfg[0].sync
    && cfg[0].irq_en == 3'h7 |=> irq[2]) else $error("wrap request missing");
  a_flag_sticky: assert property (irq[0] && cfg[0].irq_en == 3'h7
    && !(bus.wr && bus.target == TMR_TGT_STAT) |=> irq[0]) else $error("flag dropped");
  a_pwm_no_cap: assert property (cfg[0].pwm && evt[0].cap_a && !evt[0].count_pulse
    && !irq[0] |=> !irq[0]) else $error("capture acted in pwm");
  a_no_enable: assert property (cfg[1].irq_en == 3'h0 |-> irq[5:3] == 3'h0)
    else $error("request without enable");
endmodule // tmr_unit_props
`default_nettype wire

// ===== verification/tmr_cpu_model.sv
`timescale 1ns/1ns
`default_nettype none
module tmr_cpu_model
  import tmr_pkg::*;
(
  input wire logic clock,
  output var tmr_bus_t bus,
  input wire logic [15:0] rdata_q,
  input wire logic rvalid_q
);
  // ------------------------------------------------------------------
  // Bus cycle T1, T2, T3, then answer; mode bits never touched
  // ------------------------------------------------------------------
  initial bus = '0;

  task automatic access(input logic rdn, input logic [2:0] ch, input logic [2:0] tg,
      input logic [1:0] be, input logic [15:0] wd, output logic [15:0] rdo);
    tmr_bus_t b;
    b = {rdn, !rdn, TMR_PH_T1, ch, tg, be, wd};
    @(posedge clock);
    bus <= b;
    @(posedge clock);
    bus.phase <= TMR_PH_T2;
    @(posedge clock);
    bus.phase <= TMR_PH_T3;
    @(posedge clock);
    bus <= {2'h0, TMR_PH_IDLE, ~b[23:0]};
    #1;
    rdo = rvalid_q ? rdata_q : ~rdata_q;
  endtask
endmodule // tmr_cpu_model
`default_nettype wire

// ===== verification/tmr_unit_bench.sv
`timescale 1ns/1ns
`default_nettype none
module tmr_unit_bench
  import tmr_pkg::*;
;
  logic clock;
  logic rst_n;
  tmr_bus_t bus;
  tmr_cfg_t cfg [TMR_CHANS];
  tmr_evt_t evt [TMR_CHANS];
  logic [15:0] rdata_q;
  logic rvalid_q;
  logic [15:0] count_q [TMR_CHANS];
  logic [14:0] irq;
  logic irq_any;
  logic [3:0] irq_top;
  logic [15:0] rd;
  int error_cnt;
  int total_checks;

  tmr_unit u_tmr_unit (.clock(clock), .rst_n(rst_n), .bus(bus), .cfg(cfg), .evt(evt),
    .rdata_q(rdata_q), .rvalid_q(rvalid_q), .count_q(count_q), .irq(irq), .irq_any(irq_any),
    .irq_top(irq_top));
  tmr_cpu_model u_tmr_cpu_model (.clock(clock), .bus(bus), .rdata_q(rdata_q),
    .rvalid_q(rvalid_q));

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input logic rdn, input logic [2:0] ch, input logic [2:0] tg,
      input logic [1:0] be, input logic [15:0] wd, input int k, input tmr_evt_t ev);
    fork
      u_tmr_cpu_model.access(rdn, ch, tg, be, wd, rd);
      if (k > 0) begin
        repeat (k) @(posedge clock);
        evt[0] <= ev;
        @(posedge clock);
        evt[0] <= '0;
      end
    join
  endtask

  task automatic clr(input logic [2:0] ch);
    cyc(1'b1, ch, TMR_TGT_STAT, 2'h3, 16'h0000, 0, '0);
    cyc(1'b0, ch, TMR_TGT_STAT, 2'h3, 16'h0000, 0, '0);
  endtask

  task automatic pulse(input tmr_evt_t ev);
    @(posedge clock);
    evt[0] <= ev;
    @(posedge clock);
    evt[0] <= '0;
    #1;
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_reset;
    chk(count_q[0], TMR_CNT_RESET);
    chk({irq_top, 12'h000}, 16'hF000);
    cyc(1'b1, 3'h2, TMR_TGT_GRB, 2'h3, 16'h0000, 0, '0);
    chk(rd, TMR_GR_RESET);
    cyc(1'b1, 3'h5, TMR_TGT_GRA, 2'h3, 16'h0000, 0, '0);
    chk(rd, 16'h0000);
    cyc(1'b1, 3'h0, 3'h6, 2'h3, 16'h0000, 0, '0);
    chk(rd, 16'h0000);
    $display("reset test done");
  endtask

  task automatic t_capture;
    cyc(1'b0, 3'h0, TMR_TGT_CNT, 2'h3, 16'h1234, 0, '0);
    cyc(1'b1, 3'h0, TMR_TGT_GRA, 2'h3, 16'h0000, 3, 3'h2);
    chk(rd, TMR_GR_RESET);
    cyc(1'b1, 3'h0, TMR_TGT_GRA, 2'h3, 16'h0000, 0, '0);
    chk(rd, 16'h1234);
    chk(16'(irq), 16'h0001);
    cyc(1'b0, 3'h0, TMR_TGT_STAT, 2'h3, 16'h0000, 0, '0);
    chk(16'(irq), 16'h0001);
    cyc(1'b1, 3'h0, TMR_TGT_STAT, 2'h3, 16'h0000, 0, '0);
    chk(rd, 16'h0001);
    cyc(1'b0, 3'h0, TMR_TGT_STAT, 2'h3, 16'h0006, 0, '0);
    chk(16'(irq), 16'h0000);
    cyc(1'b0, 3'h0, TMR_TGT_CNT, 2'h3, 16'h0555, 0, '0);
    cyc(1'b0, 3'h0, TMR_TGT_GRA, 2'h3, 16'h7777, 3, 3'h2);
    cyc(1'b1, 3'h0, TMR_TGT_GRA, 2'h3, 16'h0000, 0, '0);
    chk(rd, 16'h0555);
    clr(3'h0);
    @(posedge clock);
    cfg[0].pwm <= 1'b1;
    pulse(3'h2);
    chk(16'(irq), 16'h0000);
    @(posedge clock);
    cfg[0].pwm <= 1'b0;
    $display("capture test done");
  endtask

  task automatic t_count;
    cyc(1'b0, 3'h0, TMR_TGT_CNT, 2'h3, 16'hFFFF, 0, '0);
    cyc(1'b0, 3'h0, TMR_TGT_CNT, 2'h3, 16'h0042, 3, 3'h4);
    chk(count_q[0], 16'h0042);
    chk(16'(irq), 16'h0004);
    clr(3'h0);
    cyc(1'b0, 3'h0, TMR_TGT_CNT, 2'h3, 16'hFFFF, 0, '0);
    pulse(3'h4);
    chk(count_q[0], 16'h0000);
    chk(16'(irq), 16'h0004);
    clr(3'h0);
    @(posedge clock);
    cfg[0].count_down <= 1'b1;
    pulse(3'h4);
    chk(count_q[0], 16'hFFFF);
    chk(16'(irq), 16'h0004);
    @(posedge clock);
    cfg[0].count_down <= 1'b0;
    clr(3'h0);
    cyc(1'b0, 3'h0, TMR_TGT_CNT, 2'h3, 16'h12FF, 0, '0);
    cyc(1'b0, 3'h0, TMR_TGT_CNT, 2'h2, 16'hAB00, 2, 3'h4);
    chk(count_q[0], 16'hABFF);
    $display("count test done");
  endtask

  task automatic t_clear;
    @(posedge clock);
    cfg[0].clr_sel <= TMR_CLR_A;
    cyc(1'b0, 3'h0, TMR_TGT_CNT, 2'h3, 16'h0100, 0, '0);
    pulse(3'h6);
    chk(count_q[0], 16'h0000);
    cyc(1'b1, 3'h0, TMR_TGT_GRA, 2'h3, 16'h0000, 0, '0);
    chk(rd, 16'h0100);
    cyc(1'b0, 3'h0, TMR_TGT_CNT, 2'h3, 16'h0300, 3, 3'h2);
    chk(count_q[0], 16'h0000);
    @(posedge clock);
    cfg[0].clr_sel <= TMR_CLR_NONE;
    clr(3'h0);
    $display("clear test done");
  endtask

  task automatic t_match;
    @(posedge clock);
    cfg[0].cap_a <= 1'b0;
    cfg[0].clr_sel <= TMR_CLR_A;
    cyc(1'b0, 3'h0, TMR_TGT_GRA, 2'h3, 16'h0002, 0, '0);
    cyc(1'b0, 3'h0, TMR_TGT_CNT, 2'h3, 16'h0000, 0, '0);
    pulse(3'h4);
    pulse(3'h4);
    chk(count_q[0], 16'h0002);
    chk(16'(irq), 16'h0000);
    pulse(3'h4);
    chk(count_q[0], 16'h0000);
    chk(16'(irq), 16'h0001);
    clr(3'h0);
    cyc(1'b0, 3'h0, TMR_TGT_CNT, 2'h3, 16'h0002, 0, '0);
    cyc(1'b0, 3'h0, TMR_TGT_GRA, 2'h3, 16'h0009, 3, 3'h4);
    chk(count_q[0], 16'h0003);
    chk(16'(irq), 16'h0000);
    @(posedge clock);
    cfg[0].cap_a <= 1'b1;
    cfg[0].clr_sel <= TMR_CLR_NONE;
    $display("match test done");
  endtask

  task automatic t_sync;
    cyc(1'b0, 3'h1, TMR_TGT_CNT, 2'h3, 16'h1200, 0, '0);
    cyc(1'b0, 3'h2, TMR_TGT_CNT, 2'h3, 16'h3456, 0, '0);
    @(posedge clock);
    cfg[1].sync <= 1'b1;
    cfg[2].sync <= 1'b1;
    cyc(1'b0, 3'h1, TMR_TGT_CNT, 2'h1, 16'h0078, 0, '0);
    chk(count_q[1], 16'h1278);
    chk(count_q[2], 16'h1278);
    @(posedge clock);
    cfg[1].sync <= 1'b0;
    cfg[2].sync <= 1'b0;
    $display("sync test done");
  endtask

  task automatic t_buf;
    cyc(1'b0, 3'h3, TMR_TGT_CNT, 2'h3, 16'h0321, 0, '0);
    @(posedge clock);
    cfg[3].buf_a <= 1'b1;
    fork
      u_tmr_cpu_model.access(1'b0, 3'h3, TMR_TGT_BRA, 2'h3, 16'h5555, rd);
      begin
        repeat (3) @(posedge clock);
        evt[3] <= 3'h2;
        @(posedge clock);
        evt[3] <= '0;
      end
    join
    cyc(1'b1, 3'h3, TMR_TGT_BRA, 2'h3, 16'h0000, 0, '0);
    chk(rd, TMR_GR_RESET);
    cyc(1'b1, 3'h3, TMR_TGT_GRA, 2'h3, 16'h0000, 0, '0);
    chk(rd, 16'h0321);
    clr(3'h3);
    @(posedge clock);
    cfg[3].buf_a <= 1'b0;
    $display("buffer test done");
  endtask

  task automatic t_prio;
    @(posedge clock);
    evt[1] <= 3'h2;
    evt[4] <= 3'h1;
    @(posedge clock);
    evt[1] <= '0;
    evt[4] <= '0;
    #1;
    chk({12'h000, irq_top}, 16'h0003);
    chk(16'(irq), 16'h2008);
    @(posedge clock);
    cfg[1].irq_en <= 3'h0;
    #1;
    chk({12'h000, irq_top}, 16'h000D);
    @(posedge clock);
    cfg[1].irq_en <= 3'h7;
    clr(3'h1);
    clr(3'h4);
    chk({irq_top, 12'h000}, 16'hF000);
    $display("priority test done");
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  initial begin
    rst_n = 1'b0;
    error_cnt = 0;
    total_checks = 0;
    for (int i = 0; i < TMR_CHANS; i++) begin
      cfg[i] = '{default: '0, cap_a: 1'b1, cap_b: 1'b1, irq_en: 3'h7};
      evt[i] = '0;
    end
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    #1;
    t_reset;
    t_capture;
    t_count;
    t_clear;
    t_match;
    t_sync;
    t_buf;
    t_prio;
    print_verdict;
  end

  initial begin
    repeat (3000) @(posedge clock);
    error_cnt++;
    print_verdict;
  end
endmodule // tmr_unit_bench

bind tmr_unit tmr_unit_props #(.CHANS(CHANS)) u_tmr_unit_props (.clock(clock), .rst_n(rst_n),
  .bus(bus), .cfg(cfg), .evt(evt), .rdata_q(rdata_q), .rvalid_q(rvalid_q), .count_q(count_q),
  .irq(irq), .irq_any(irq_any), .irq_top(irq_top));
`default_nettype wire
